/* File: cfg_mode_pkg.sv */
package cfg_mode_pkg;
	typedef enum logic [1:0] {
		MODE_SERIAL = 2'h0,
		MODE_COMBINED = 2'h1,
		MODE_STRAP = 2'h3
	} cfg_mode_t;
	// four-level strap codes: ground, three-eighths, five-eighths, supply
	localparam logic [1:0] LEVEL_GND = 2'h0;
	localparam logic [1:0] LEVEL_3_8 = 2'h1;
	localparam logic [1:0] LEVEL_5_8 = 2'h2;
	localparam logic [1:0] LEVEL_VDD = 2'h3;
	localparam logic [2:0] CTRL_NORMAL = 3'h0;
	localparam logic [2:0] CTRL_SHAPE_B = 3'h1;
	localparam logic [2:0] CTRL_SHAPE_A = 3'h2;
	localparam logic [2:0] CTRL_SHAPE_AB = 3'h3;
	localparam logic [2:0] CTRL_POWER_DOWN = 3'h4;
	localparam logic [2:0] CTRL_STANDBY_B = 3'h5;
	localparam logic [2:0] CTRL_STANDBY_A = 3'h6;
	localparam logic [2:0] CTRL_INTERLEAVE = 3'h7;
	// reset pin high longer than this counts as tied high
	localparam int STRAP_HOLD_NS = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam logic [7:0] STRAP_HOLD_CYCLES = 8'((STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int SYNC_STAGES = 2;
endpackage : cfg_mode_pkg

/* File: level_sync.sv */
`timescale 1ns/10ps
module level_sync (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [6:0] d_i,
	output logic [6:0] q_o
);
	logic [6:0] stage [cfg_mode_pkg::SYNC_STAGES];
	logic [6:0] next_stage [cfg_mode_pkg::SYNC_STAGES];
	genvar g;
	generate
		for (g = 0; g < cfg_mode_pkg::SYNC_STAGES; g++) begin : g_stage
			// first stage takes the pin, later stages the stage before
			if (g == 0) begin : g_first
				always_comb begin
					next_stage[g] = d_i;
				end
			end else begin : g_next
				always_comb begin
					next_stage[g] = stage[g - 1];
				end
			end
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					stage[g] <= 7'h00;
				end else begin
					stage[g] <= next_stage[g];
				end
			end
		end
	endgenerate
	assign q_o = stage[cfg_mode_pkg::SYNC_STAGES - 1];
endmodule : level_sync

/* File: adc_config_mode_decoder.sv */
`timescale 1ns/10ps
module adc_config_mode_decoder (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reset_pin_i,
	input wire logic [1:0] serial_clock_level_i,
	input wire logic [1:0] serial_enable_level_i,
	input wire logic mode_pin_one_i,
	input wire logic mode_pin_two_i,
	input wire logic mode_pin_three_i,
	input wire logic reg_init_write_i,
	input wire logic reg_shape_a_i,
	input wire logic reg_shape_b_i,
	input wire logic reg_ext_ref_i,
	input wire logic reg_twos_comp_i,
	input wire logic reg_cmos_i,
	input wire logic reg_power_down_i,
	input wire logic reg_standby_a_i,
	input wire logic reg_standby_b_i,
	input wire logic reg_interleave_i,
	output logic [1:0] cfg_mode_o,
	output logic serial_port_enable_o,
	output logic reg_defaults_o,
	output logic reg_init_bit_o,
	output logic ext_ref_o,
	output logic twos_comp_o,
	output logic cmos_out_o,
	output logic noise_shaping_enable_a_o,
	output logic noise_shaping_enable_b_o,
	output logic power_down_o,
	output logic standby_a_o,
	output logic standby_b_o,
	output logic channel_interleave_mode_o
);
	// ************************************************************
	// pin synchroniser
	// ************************************************************
	logic [6:0] pins_sync;
	level_sync u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i({reset_pin_i, serial_clock_level_i, serial_enable_level_i, mode_pin_one_i, mode_pin_two_i}),
		.q_o(pins_sync)
	);
	// pin three rides a separate path to keep the bus width at seven
	logic pin3_meta;
	logic pin3_sync;
	logic next_pin3_meta;
	logic next_pin3_sync;
	always_comb begin
		next_pin3_meta = mode_pin_three_i;
		next_pin3_sync = pin3_meta;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin3_meta <= 1'b0;
			pin3_sync <= 1'b0;
		end else begin
			pin3_meta <= next_pin3_meta;
			pin3_sync <= next_pin3_sync;
		end
	end
	logic rst_pin;
	logic [1:0] clk_lvl;
	logic [1:0] en_lvl;
	logic [2:0] ctrl;
	always_comb begin
		rst_pin = pins_sync[6];
		clk_lvl = pins_sync[5:4];
		en_lvl = pins_sync[3:2];
		ctrl = {pins_sync[1:0], pin3_sync};
	end
	// ************************************************************
	// configuration mode tracking
	// ************************************************************
	// short high pulses are register resets; only a long hold means strapping
	logic [7:0] high_count;
	logic [7:0] next_high_count;
	logic rst_pin_d;
	logic pins_used;
	logic next_pins_used;
	cfg_mode_pkg::cfg_mode_t mode;
	cfg_mode_pkg::cfg_mode_t next_mode;
	logic defaults;
	logic next_defaults;
	logic init_bit;
	logic next_init_bit;
	always_comb begin
		next_high_count = high_count;
		next_mode = mode;
		next_pins_used = pins_used;
		next_defaults = 1'b0;
		next_init_bit = init_bit;
		if (rst_pin) begin
			if (high_count < cfg_mode_pkg::STRAP_HOLD_CYCLES) begin
				next_high_count = high_count + 8'h01;
			end else begin
				next_mode = cfg_mode_pkg::MODE_STRAP;
			end
		end else begin
			next_high_count = 8'h00;
			if (mode == cfg_mode_pkg::MODE_STRAP) begin
				next_mode = pins_used ? cfg_mode_pkg::MODE_COMBINED : cfg_mode_pkg::MODE_SERIAL;
			end
		end
		// falling edge of a reset pulse restores defaults
		if (rst_pin_d && !rst_pin) begin
			next_defaults = 1'b1;
		end
		if (reg_init_write_i) begin
			next_init_bit = 1'b1;
		end else if (init_bit) begin
			next_defaults = 1'b1;
			next_init_bit = 1'b0;
		end
		// any control pin high after power-up means the board uses them
		if (ctrl != cfg_mode_pkg::CTRL_NORMAL) begin
			next_pins_used = 1'b1;
		end
		if (mode != cfg_mode_pkg::MODE_STRAP) begin
			next_mode = next_pins_used ? cfg_mode_pkg::MODE_COMBINED : cfg_mode_pkg::MODE_SERIAL;
		end
		if (next_high_count >= cfg_mode_pkg::STRAP_HOLD_CYCLES) begin
			next_mode = cfg_mode_pkg::MODE_STRAP;
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			high_count <= 8'h00;
			rst_pin_d <= 1'b0;
			mode <= cfg_mode_pkg::MODE_SERIAL;
			pins_used <= 1'b0;
			defaults <= 1'b0;
			init_bit <= 1'b0;
		end else begin
			high_count <= next_high_count;
			rst_pin_d <= rst_pin;
			mode <= next_mode;
			pins_used <= next_pins_used;
			defaults <= next_defaults;
			init_bit <= next_init_bit;
		end
	end
	// ************************************************************
	// mode decode
	// ************************************************************
	logic [12:0] outs;
	logic [12:0] next_outs;
	logic shape_a;
	logic shape_b;
	logic pd;
	logic sb_a;
	logic sb_b;
	logic ilv;
	logic strap;
	logic use_pins;
	always_comb begin
		strap = (mode == cfg_mode_pkg::MODE_STRAP);
		use_pins = (mode != cfg_mode_pkg::MODE_SERIAL);
		shape_a = 1'b0;
		shape_b = 1'b0;
		pd = 1'b0;
		sb_a = 1'b0;
		sb_b = 1'b0;
		ilv = 1'b0;
		case (ctrl)
			cfg_mode_pkg::CTRL_NORMAL: begin
			end
			cfg_mode_pkg::CTRL_SHAPE_B: shape_b = 1'b1;
			cfg_mode_pkg::CTRL_SHAPE_A: shape_a = 1'b1;
			cfg_mode_pkg::CTRL_SHAPE_AB: begin
				shape_a = 1'b1;
				shape_b = 1'b1;
			end
			cfg_mode_pkg::CTRL_POWER_DOWN: pd = 1'b1;
			cfg_mode_pkg::CTRL_STANDBY_B: sb_b = 1'b1;
			cfg_mode_pkg::CTRL_STANDBY_A: sb_a = 1'b1;
			cfg_mode_pkg::CTRL_INTERLEAVE: ilv = 1'b1;
			default: begin
			end
		endcase
		if (!use_pins) begin
			{shape_a, shape_b, pd, sb_a, sb_b, ilv} = 6'h00;
		end
		next_outs[12:11] = mode;
		next_outs[10] = !strap;
		if (strap) begin
			next_outs[9] = (clk_lvl == cfg_mode_pkg::LEVEL_3_8) || (clk_lvl == cfg_mode_pkg::LEVEL_5_8);
			next_outs[8] = (en_lvl == cfg_mode_pkg::LEVEL_3_8) || (en_lvl == cfg_mode_pkg::LEVEL_5_8);
			next_outs[7] = (en_lvl == cfg_mode_pkg::LEVEL_5_8) || (en_lvl == cfg_mode_pkg::LEVEL_VDD);
		end else begin
			next_outs[9] = reg_ext_ref_i;
			next_outs[8] = reg_twos_comp_i;
			next_outs[7] = reg_cmos_i;
		end
		// a set register enable wins; both clear hands control to the pins, except in serial mode where the pin decode is forced off
		next_outs[6] = reg_shape_a_i || shape_a;
		next_outs[5] = reg_shape_b_i || shape_b;
		next_outs[4] = pd || (!strap && reg_power_down_i);
		next_outs[3] = sb_a || (!strap && reg_standby_a_i);
		next_outs[2] = sb_b || (!strap && reg_standby_b_i);
		next_outs[1] = ilv || (!strap && reg_interleave_i);
		next_outs[0] = 1'b0;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			outs <= 13'h0000;
		end else begin
			outs <= next_outs;
		end
	end
	assign cfg_mode_o = outs[12:11];
	assign serial_port_enable_o = outs[10];
	assign ext_ref_o = outs[9];
	assign twos_comp_o = outs[8];
	assign cmos_out_o = outs[7];
	assign noise_shaping_enable_a_o = outs[6];
	assign noise_shaping_enable_b_o = outs[5];
	assign power_down_o = outs[4];
	assign standby_a_o = outs[3];
	assign standby_b_o = outs[2];
	assign channel_interleave_mode_o = outs[1];
	assign reg_defaults_o = defaults;
	assign reg_init_bit_o = init_bit;
endmodule : adc_config_mode_decoder

/* File: adc_config_mode_decoder_sva.sv */
`timescale 1ns/10ps
module adc_config_mode_decoder_chk (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reset_pin_i,
	input wire logic [1:0] serial_clock_level_i,
	input wire logic [1:0] serial_enable_level_i,
	input wire logic mode_pin_one_i,
	input wire logic mode_pin_two_i,
	input wire logic mode_pin_three_i,
	input wire logic reg_init_write_i,
	input wire logic reg_shape_a_i,
	input wire logic reg_shape_b_i,
	input wire logic [1:0] cfg_mode_o,
	input wire logic serial_port_enable_o,
	input wire logic reg_defaults_o,
	input wire logic reg_init_bit_o,
	input wire logic ext_ref_o,
	input wire logic twos_comp_o,
	input wire logic cmos_out_o,
	input wire logic noise_shaping_enable_a_o,
	input wire logic noise_shaping_enable_b_o,
	input wire logic power_down_o,
	input wire logic standby_a_o,
	input wire logic standby_b_o,
	input wire logic channel_interleave_mode_o
);
	// ****
	// helpers
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire [2:0] c = {mode_pin_one_i, mode_pin_two_i, mode_pin_three_i};
	logic [6:0] hi_cnt;
	logic [6:0] next_hi_cnt;
	// saturates so a tied-high pin stays counted
	always_comb next_hi_cnt = !reset_pin_i ? 7'h00 : (hi_cnt == 7'h7f ? hi_cnt : hi_cnt + 7'h01);
	always_ff @(posedge clk_i) hi_cnt <= reset_i ? 7'h00 : next_hi_cnt;
	// three cycles of strap mode so the sync pipe holds real pin levels
	sequence s_strap;
		cfg_mode_o == 2'h3 && $past(cfg_mode_o, 3) == 2'h3;
	endsequence
	sequence s_init;
		$rose(reg_init_write_i) ##1 !reg_init_write_i;
	endsequence
	a_strap_entry: assert property (hi_cnt == 7'h6e |-> cfg_mode_o == 2'h3 && !serial_port_enable_o)
		else $error("strap mode not entered");
	a_ref_select: assert property (s_strap |-> ext_ref_o == ^$past(serial_clock_level_i, 3))
		else $error("reference select wrong");
	a_format_select: assert property (s_strap |-> twos_comp_o == ^$past(serial_enable_level_i, 3)
		&& cmos_out_o == $past(serial_enable_level_i[1], 3)) else $error("format select wrong");
	a_shape_decode: assert property (s_strap ##0 !(reg_shape_a_i | reg_shape_b_i | $past(reg_shape_a_i | reg_shape_b_i))
		|-> {noise_shaping_enable_a_o, noise_shaping_enable_b_o} == ($past(c[2], 3) ? 2'h0 : $past(c[1:0], 3)))
		else $error("shaping decode wrong");
	a_standby_decode: assert property (s_strap |-> {power_down_o, standby_a_o, standby_b_o}
		== {$past(c, 3) == 3'h4, $past(c, 3) == 3'h6, $past(c, 3) == 3'h5}) else $error("standby decode wrong");
	a_interleave_sel: assert property (s_strap |-> channel_interleave_mode_o == ($past(c, 3) == 3'h7))
		else $error("interleave decode wrong");
	a_init_walk: assert property (s_init |-> reg_init_bit_o ##1 (reg_defaults_o && !reg_init_bit_o))
		else $error("init bit sequence wrong");
	a_pin_reset: assert property ($fell(reset_pin_i) |-> ##[2:4] reg_defaults_o)
		else $error("pin reset gave no defaults");
	a_serial_port: assert property (cfg_mode_o != 2'h3 && !$past(reset_i) |-> serial_port_enable_o)
		else $error("serial port off outside strap");
endmodule : adc_config_mode_decoder_chk

bind adc_config_mode_decoder adc_config_mode_decoder_chk chk_u (.*);

/* File: strap_board.sv */
`timescale 1ns/10ps
module strap_board #(
	parameter int SAMPLE_MSPS = 100
) (
	input wire logic hold_high_i,
	input wire logic pulse_i,
	input wire logic [6:0] pins_i,
	output logic reset_pin_o,
	output logic [6:0] pins_o,
	output logic low_speed_o
);
	// controller asks for low-speed operation at slow sample rates
	assign low_speed_o = (SAMPLE_MSPS >= 1) && (SAMPLE_MSPS <= 100);
	// tied high for strap use, else low apart from a reset pulse
	assign reset_pin_o = hold_high_i | pulse_i;
	// static levels only, no serial traffic; shaping regs left clear
	assign pins_o = pins_i;
endmodule : strap_board

/* File: adc_config_mode_decoder_test.sv */
`timescale 1ns/10ps
module adc_config_mode_decoder_test;
	logic clk_i = 0, reset_i = 1, hold = 0, pulse = 0, reg_init_write_i = 0;
	logic [6:0] pins = 7'h00;
	logic [8:0] regs = 9'h000;
	int errors = 0, comparisons = 0;
	wire reset_pin_i, mode_pin_one_i, mode_pin_two_i, mode_pin_three_i;
	wire [1:0] serial_clock_level_i, serial_enable_level_i, cfg_mode_o;
	wire reg_shape_a_i, reg_shape_b_i, reg_ext_ref_i, reg_twos_comp_i, reg_cmos_i, reg_power_down_i;
	wire reg_standby_a_i, reg_standby_b_i, reg_interleave_i, serial_port_enable_o, reg_defaults_o, reg_init_bit_o;
	wire ext_ref_o, twos_comp_o, cmos_out_o, noise_shaping_enable_a_o, noise_shaping_enable_b_o;
	wire power_down_o, standby_a_o, standby_b_o, channel_interleave_mode_o;
	assign {reg_shape_a_i, reg_shape_b_i, reg_ext_ref_i, reg_twos_comp_i, reg_cmos_i, reg_power_down_i,
		reg_standby_a_i, reg_standby_b_i, reg_interleave_i} = regs;
	adc_config_mode_decoder dut_u (.*);
	strap_board board_u (.hold_high_i(hold), .pulse_i(pulse), .pins_i(pins), .reset_pin_o(reset_pin_i), .low_speed_o(),
		.pins_o({serial_clock_level_i, serial_enable_level_i, mode_pin_one_i, mode_pin_two_i, mode_pin_three_i}));
	// ****
	// helpers
	// ****
	task tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick
	task check(input string n, input logic [3:0] seen, input logic [3:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	// ****
	// scenarios
	// ****
	task t_init;
		reg_init_write_i = 1;
		tick(1);
		// bit reads back high one edge after the write is taken
		check("init bit", reg_init_bit_o, 1);
		reg_init_write_i = 0;
		tick(1);
		check("defaults", {reg_defaults_o, reg_init_bit_o}, 2);
	endtask : t_init
	task t_pin_pulse;
		logic seen;
		seen = 0;
		pulse = 1;
		tick(5);
		pulse = 0;
		repeat (8) begin
			tick(1);
			seen |= reg_defaults_o;
		end
		check("pulse defaults", seen, 1);
		check("serial mode", {cfg_mode_o, serial_port_enable_o}, 1);
	endtask : t_pin_pulse
	task t_combined;
		pins = 7'h01;
		regs = 9'h070;
		tick(5);
		check("combined mode", cfg_mode_o, 1);
		check("combined shaping", {noise_shaping_enable_a_o, noise_shaping_enable_b_o}, 1);
		check("combined regs", {ext_ref_o, twos_comp_o, cmos_out_o}, 7);
		check("combined power", power_down_o, 0);
		regs = 9'h10f;
		tick(2);
		check("combined reg modes", {power_down_o, standby_a_o, standby_b_o, channel_interleave_mode_o}, 4'hf);
		check("combined reg shaping", {noise_shaping_enable_a_o, noise_shaping_enable_b_o}, 3);
		regs = 9'h000;
	endtask : t_combined
	task t_strap;
		hold = 1;
		pins = 7'h00;
		tick(110);
		check("strap mode", {cfg_mode_o, serial_port_enable_o}, 6);
		for (int i = 0; i < 16; i++) begin
			pins = {i[3:0], 3'h0};
			tick(4);
			check("reference", ext_ref_o, ^i[3:2]);
			check("format", {twos_comp_o, cmos_out_o}, {^i[1:0], i[1]});
		end
		for (int k = 0; k < 8; k++) begin
			pins = {4'h0, k[2:0]};
			tick(4);
			check("shaping", {noise_shaping_enable_a_o, noise_shaping_enable_b_o}, k[2] ? 0 : k[1:0]);
			check("standby", {power_down_o, standby_a_o, standby_b_o}, {k == 4, k == 6, k == 5});
			check("interleave", channel_interleave_mode_o, k == 7);
		end
		pins = 7'h00;
		regs = 9'h100;
		tick(4);
		check("reg shaping", noise_shaping_enable_a_o, 1);
		regs = 9'h000;
		hold = 0;
		tick(6);
	endtask : t_strap
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		tick(3);
		reset_i = 0;
		tick(2);
		t_init();
		t_pin_pulse();
		t_combined();
		t_strap();
		give_verdict();
	end
	// the run needs well under a thousand cycles
	initial begin
		#20000;
		errors++;
		give_verdict();
	end
endmodule : adc_config_mode_decoder_test
